/* core/tsdf_coarse.sv */
module tsdf_coarse import tsdf_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_strobe,
  input wire logic [SMP_W-1:0] i_sample,
  input wire logic i_bypass,
  input wire logic [2:0] i_stages,
  input wire logic [5:0] i_growth,
  input wire logic [9:0] i_ratio,
  tsdf_stream_if.src o_out
);
  typedef struct packed {
    logic [CIC_STAGES-1:0][CIC_W-1:0] integ;
    logic [CIC_STAGES-1:0][CIC_W-1:0] dly;
    logic [9:0] cnt;
    logic vld;
    logic [CRS_W-1:0] dat;
  } tsdf_coarse_st_t;

  tsdf_coarse_st_t r, n;
  logic [CIC_W-1:0] top;
  logic signed [CIC_W-1:0] c;

  assign o_out.valid = r.vld;
  assign o_out.data = r.dat;

  always_comb begin
    n = r;
    top = '0;
    c = '0;
    n.vld = r.vld & ~o_out.ready;
    if (i_strobe) begin
      if (i_bypass) begin
        n.dat = {i_sample, (CRS_W - SMP_W)'(0)};
        n.vld = 1'b1;
      end else begin
        // input aligned so growth lands above the sample's msb
        top = CIC_W'(signed'({i_sample, (CRS_W - SMP_W)'(0)}));
        for (int k = 0; k < CIC_STAGES; k++) begin
          if (k < int'(i_stages)) begin
            n.integ[k] = r.integ[k] + top;
            top = r.integ[k];
          end
        end
        if (r.cnt == i_ratio) begin
          n.cnt = '0;
          c = signed'(top);
          for (int k = 0; k < CIC_STAGES; k++) begin
            if (k < int'(i_stages)) begin
              n.dly[k] = c;
              c = c - signed'(r.dly[k]);
            end
          end
          n.dat = CRS_W'(c >>> i_growth);
          n.vld = 1'b1;
        end else begin
          n.cnt = r.cnt + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

/* core/tsdf_fifo.sv */
module tsdf_fifo import tsdf_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  tsdf_stream_if.snk i_in,
  tsdf_stream_if.src o_out
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tsdf_fifo_st_t;

  tsdf_fifo_st_t r, n;
  logic push;
  logic pop;

  assign push = i_in.valid && (r.cnt != CNT_FULL);
  assign pop = o_out.ready && (r.cnt != '0);
  assign i_in.ready = (r.cnt != CNT_FULL);
  assign o_out.valid = (r.cnt != '0);
  assign o_out.data = r.mem[r.rp];

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = i_in.data;
      n.wp = r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = r.rp + AW'(1);
    end
    if (push && !pop) begin
      n.cnt = r.cnt + (AW + 1)'(1);
    end else if (pop && !push) begin
      n.cnt = r.cnt - (AW + 1)'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

/* core/tsdf_pkg.sv */
package tsdf_pkg;
  localparam int SMP_W = 16;
  localparam int PAR_W = 16;
  localparam int RES_W = 24;
  localparam int LO_W = 16;
  localparam int HI_W = 8;
  localparam int COEF_W = 20;
  localparam int HALF_TAPS = 256;
  localparam int LINE_LEN = 512;
  localparam int CIC_STAGES = 5;
  localparam int CIC_W = 66;
  localparam int CRS_W = 32;
  localparam int ACC_W = 45;
  localparam int FIFO_W = ACC_W + 1;
  localparam int FIFO_D = 8;

  // register select codes
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_CRATIO = 2'h1;
  localparam logic [1:0] REG_FINE = 2'h2;
  localparam logic [1:0] REG_COEF = 2'h3;

  // field positions
  localparam int CTL_FBYP_BIT = 0;
  localparam int CTL_CBYP_BIT = 1;
  localparam int CTL_FDIS_BIT = 2;
  localparam int CTL_STG_LSB = 4;
  localparam int CTL_GROW_LSB = 8;
  localparam int FINE_RATIO_LSB = 0;
  localparam int FINE_TAPS_LSB = 4;
  localparam int COEF_HI_LSB = 0;

  // result word slices of the fir accumulator (lsb weight 2^-34)
  localparam int ACC_LO_LSB = 19;
  localparam int ACC_MID_LSB = 11;
  localparam int ACC_GROW_LSB = 35;

  // reset values
  localparam logic RST_FBYP = 1'b0;
  localparam logic RST_CBYP = 1'b0;
  localparam logic RST_FDIS = 1'b1;
  localparam logic [2:0] RST_STAGES = 3'h0;
  localparam logic [5:0] RST_GROWTH = 6'h00;
  localparam logic [9:0] RST_CRATIO = 10'h000;
  localparam logic [3:0] RST_FRATIO = 4'h0;
  localparam logic [7:0] RST_TAPS = 8'h00;

  typedef struct packed {
    logic sclk;
    logic fclk;
    logic cs_n;
    logic wr_n;
    logic [1:0] sel;
    logic ubs;
    logic lo_en_n;
    logic hi_en_n;
    logic [PAR_W-1:0] par;
    logic [SMP_W-1:0] smp;
  } tsdf_pins_t;

  localparam tsdf_pins_t PINS_RST = '{cs_n: 1'b1, wr_n: 1'b1, lo_en_n: 1'b1, hi_en_n: 1'b1, default: '0};

  typedef enum logic [1:0] {ST_IDLE, ST_MAC, ST_PUSH} tsdf_fir_st_t;
endpackage

/* core/tsdf_stream_if.sv */
interface tsdf_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

/* core/tsdf_top.sv */
// Overview of operation
// - coarse decimator advances only on rising sample clock edges, up to 33MHz.
// - fir stage advances only on rising filter clock edges, up to 33MHz.
// - 16-bit two's complement samples, bit 15 msb, taken on sample clock rise.
// - parameters load over 16-bit bus, target chosen by register select.
// - each filtered result leaves as a 24-bit two's complement word.
// - low result bits weigh 2^0..2^-15, or 2^-16..2^-31 when fir bypassed.
// - upper result byte holds fraction or growth bits per select, coarse word bits 23..16 when fir bypassed.
// - result-valid strobe high, on filter clock, when finished fir result shows.
// - coarse decimator reduces rate by programmable factors up to 1024.
// - fir is transversal, up to 512 symmetric taps, 20-bit coefficients.
// - fir optionally decimates further by factors up to 16.
// - coarse decimator or fir stage can each be bypassed by configuration.
// - result bus drivers are three-state for a shared output bus.
// - with select and strobe low, strobe rising edge loads the chosen register.
// - with fir active, upper byte select low gives weights 2^-16..2^-23, high gives growth bits.
// - low word enable high floats low 16 result bits; processing continues.
// - reset clears coarse data, bypass, stage count, ratio; sets fine disable.
module tsdf_top import tsdf_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_sample_clock,
  input wire logic i_filter_clock,
  input wire logic [SMP_W-1:0] i_sample_input_bus,
  input wire logic [PAR_W-1:0] i_parameter_bus,
  input wire logic [1:0] i_register_select,
  input wire logic i_chip_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_upper_byte_select,
  input wire logic i_low_word_output_enable_n,
  input wire logic i_high_byte_output_enable_n,
  output logic [RES_W-1:0] o_result_bus,
  output logic [RES_W-1:0] o_result_bus_oe,
  output logic o_result_valid
);
  typedef struct packed {
    tsdf_pins_t s1;
    tsdf_pins_t s2;
    tsdf_pins_t s3;
    tsdf_pins_t dl;
    logic sclk_l;
    logic fclk_l;
    logic wr_l;
    logic fbyp;
    logic cbyp;
    logic fdis;
    logic [2:0] stages;
    logic [5:0] growth;
    logic [9:0] cratio;
    logic [3:0] fratio;
    logic [7:0] taps;
    logic [7:0] cptr;
    logic chalf;
    logic [PAR_W-1:0] clo;
    logic [HALF_TAPS-1:0][COEF_W-1:0] coef;
    logic [LINE_LEN-1:0][SMP_W-1:0] dline;
    logic [8:0] wp;
    logic [3:0] fcnt;
    logic pend;
    tsdf_fir_st_t st;
    logic [8:0] base;
    logic [7:0] idx;
    logic [ACC_W-1:0] acc;
    logic pv;
    logic [FIFO_W-1:0] pd;
    logic [RES_W-1:0] res;
    logic [RES_W-1:0] oe;
    logic rdy;
  } tsdf_top_st_t;

  localparam tsdf_top_st_t TOP_RST = '{
    s1: PINS_RST,
    s2: PINS_RST,
    s3: PINS_RST,
    dl: PINS_RST,
    wr_l: 1'b1,
    fbyp: RST_FBYP,
    cbyp: RST_CBYP,
    fdis: RST_FDIS,
    stages: RST_STAGES,
    growth: RST_GROWTH,
    cratio: RST_CRATIO,
    fratio: RST_FRATIO,
    taps: RST_TAPS,
    st: ST_IDLE,
    default: '0
  };

  tsdf_top_st_t r, n;
  tsdf_pins_t pins;
  logic se;
  logic fe;
  logic we;
  logic busy;
  logic took;
  logic pset;
  logic [8:0] nn;
  logic signed [SMP_W-1:0] a;
  logic signed [SMP_W-1:0] b;
  logic signed [SMP_W:0] psum;
  logic signed [SMP_W+COEF_W:0] prod;

  tsdf_stream_if #(.W(CRS_W)) crs_if();
  tsdf_stream_if #(.W(FIFO_W)) fin_if();
  tsdf_stream_if #(.W(FIFO_W)) fout_if();

  // accepted edge: second and third stage agree on a new high level
  function automatic logic rise(input logic s2, input logic s3, input logic lvl);
    return s2 & s3 & ~lvl;
  endfunction

  function automatic logic track(input logic s2, input logic s3, input logic lvl);
    return (s2 == s3) ? s2 : lvl;
  endfunction

  function automatic logic [RES_W-1:0] fmt(input logic [FIFO_W-1:0] d, input logic ubs);
    logic [RES_W-1:0] w;
    w = '0;
    if (d[FIFO_W-1]) begin
      w = d[RES_W-1:0];
    end else begin
      w[LO_W-1:0] = d[ACC_LO_LSB +: LO_W];
      w[RES_W-1:LO_W] = ubs ? d[ACC_GROW_LSB +: HI_W] : d[ACC_MID_LSB +: HI_W];
    end
    return w;
  endfunction

  assign pins = '{
    sclk: i_sample_clock,
    fclk: i_filter_clock,
    cs_n: i_chip_select_n,
    wr_n: i_write_strobe_n,
    sel: i_register_select,
    ubs: i_upper_byte_select,
    lo_en_n: i_low_word_output_enable_n,
    hi_en_n: i_high_byte_output_enable_n,
    par: i_parameter_bus,
    smp: i_sample_input_bus
  };

  assign se = rise(r.s2.sclk, r.s3.sclk, r.sclk_l);
  assign fe = rise(r.s2.fclk, r.s3.fclk, r.fclk_l);
  assign we = rise(r.s2.wr_n, r.s3.wr_n, r.wr_l);
  assign busy = r.pv & ~fin_if.ready;
  assign pset = crs_if.valid && !r.fbyp && (r.fcnt == r.fratio);

  assign crs_if.ready = 1'b1;
  assign fin_if.valid = r.pv;
  assign fin_if.data = r.pd;
  // drain only on filter edges, one result per filter period
  assign fout_if.ready = fe;

  tsdf_coarse u_coarse (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_strobe(se),
    .i_sample(r.dl.smp),
    .i_bypass(r.cbyp),
    .i_stages(r.stages),
    .i_growth(r.growth),
    .i_ratio(r.cratio),
    .o_out(crs_if)
  );

  tsdf_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_in(fin_if),
    .o_out(fout_if)
  );

  always_comb begin
    n = r;
    took = 1'b0;
    nn = '0;
    a = '0;
    b = '0;
    psum = '0;
    prod = '0;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // dl holds the level seen just before the accepted edge
    n.dl = r.s3;
    n.sclk_l = track(r.s2.sclk, r.s3.sclk, r.sclk_l);
    n.fclk_l = track(r.s2.fclk, r.s3.fclk, r.fclk_l);
    n.wr_l = track(r.s2.wr_n, r.s3.wr_n, r.wr_l);

    if (we && !r.dl.cs_n) begin
      case (r.dl.sel)
        REG_CTRL: begin
          n.fbyp = r.dl.par[CTL_FBYP_BIT];
          n.cbyp = r.dl.par[CTL_CBYP_BIT];
          n.fdis = r.dl.par[CTL_FDIS_BIT];
          n.stages = r.dl.par[CTL_STG_LSB +: 3];
          n.growth = r.dl.par[CTL_GROW_LSB +: 6];
        end
        REG_CRATIO: begin
          n.cratio = r.dl.par[9:0];
        end
        REG_FINE: begin
          n.fratio = r.dl.par[FINE_RATIO_LSB +: 4];
          n.taps = r.dl.par[FINE_TAPS_LSB +: 8];
          n.cptr = '0;
          n.chalf = 1'b0;
        end
        REG_COEF: begin
          // two writes per coefficient: low word first, then top bits
          if (!r.chalf) begin
            n.clo = r.dl.par;
            n.chalf = 1'b1;
          end else begin
            n.coef[r.cptr] = {r.dl.par[COEF_HI_LSB +: COEF_W - PAR_W], r.clo};
            n.cptr = r.cptr + 8'h01;
            n.chalf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (r.pv && fin_if.ready) begin
      n.pv = 1'b0;
    end

    if (crs_if.valid) begin
      if (r.fbyp) begin
        // no way to stall the source here: a full fifo with a word already staged drops the word
        if (!busy) begin
          n.pv = 1'b1;
          n.pd = {1'b1, ACC_W'(signed'(crs_if.data))};
          took = 1'b1;
        end
      end else begin
        n.dline[r.wp] = crs_if.data[CRS_W-1 -: SMP_W];
        n.wp = r.wp + 9'h001;
        if (r.fcnt == r.fratio) begin
          n.fcnt = '0;
          n.pend = 1'b1;
        end else begin
          n.fcnt = r.fcnt + 4'h1;
        end
      end
    end
    if (r.fdis) begin
      n.pend = 1'b0;
    end

    case (r.st)
      ST_IDLE: begin
        if (fe && r.pend && !r.fdis) begin
          // a coarse word completing the fine ratio count in this cycle keeps pend set
          n.pend = pset;
          n.base = r.wp;
          n.idx = '0;
          n.acc = '0;
          n.st = ST_MAC;
        end
      end
      ST_MAC: begin
        // one symmetric pair per filter edge; long filters need
        // the input rate low enough not to overrun the delay line
        if (fe) begin
          nn = {r.taps, 1'b0} + 9'h002;
          a = r.dline[r.base - 9'h001 - 9'(r.idx)];
          b = r.dline[r.base - nn + 9'(r.idx)];
          psum = (SMP_W + 1)'(a) + (SMP_W + 1)'(b);
          prod = psum * signed'(r.coef[r.idx]);
          n.acc = r.acc + ACC_W'(prod);
          if (r.idx == r.taps) begin
            n.st = ST_PUSH;
          end else begin
            n.idx = r.idx + 8'h01;
          end
        end
      end
      ST_PUSH: begin
        if (!busy && !took) begin
          n.pv = 1'b1;
          n.pd = {1'b0, r.acc};
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (fe) begin
      n.rdy = fout_if.valid;
      if (fout_if.valid) begin
        n.res = fmt(fout_if.data, r.s3.ubs);
      end
    end
    n.oe = {{HI_W{~r.s3.hi_en_n}}, {LO_W{~r.s3.lo_en_n}}};
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= TOP_RST;
    end else begin
      r <= n;
    end
  end

  assign o_result_bus = r.res;
  assign o_result_bus_oe = r.oe;
  assign o_result_valid = r.rdy;
endmodule

/* sim/test_two_stage_decimating_filter.sv */
module test_two_stage_decimating_filter import tsdf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  logic ubs;
  logic lo_n;
  logic hi_n;
  logic sclk;
  logic fclk;
  logic cs_n;
  logic wr_n;
  logic vld;
  logic [1:0] sel;
  logic [SMP_W-1:0] smp;
  logic [PAR_W-1:0] par;
  logic [RES_W-1:0] res;
  logic [RES_W-1:0] oe;
  int failures = 0;
  int n_checks = 0;
  int k;
  tsdf_source src (.i_core_clk(clk), .o_sample_clock(sclk), .o_filter_clock(fclk), .o_sample(smp), .o_par(par),
    .o_sel(sel), .o_cs_n(cs_n), .o_wr_n(wr_n));
  tsdf_top uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_sample_clock(sclk), .i_filter_clock(fclk),
    .i_sample_input_bus(smp), .i_parameter_bus(par), .i_register_select(sel), .i_chip_select_n(cs_n),
    .i_write_strobe_n(wr_n), .i_upper_byte_select(ubs), .i_low_word_output_enable_n(lo_n),
    .i_high_byte_output_enable_n(hi_n), .o_result_bus(res), .o_result_bus_oe(oe), .o_result_valid(vld));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one look per filter period, since back-to-back results keep valid high
  task automatic count_res(input int periods, output int n);
    n = 0;
    repeat (periods) begin
      @(posedge fclk);
      repeat (6) @(posedge clk);
      #1;
      if (vld === 1'b1)
        n++;
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic t_quiet();
    lo_n = 1'b1;
    hi_n = 1'b0;
    count_res(20, k);
    check("quiet results", 24'(k), 24'h000000);
    check("quiet word", res, 24'h000000);
    check("split enables", oe, 24'hFF0000);
    lo_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 check("all enables", oe, 24'hFFFFFF);
    $display("test quiet done");
  endtask
  task automatic t_bypass();
    src.wr(REG_CRATIO, 16'h0000);
    src.wr(REG_CTRL, 16'h0801);
    ubs = 1'b0;
    count_res(12, k);
    check("bypass word", res, 24'hC00100);
    ubs = 1'b1;
    count_res(12, k);
    check("bypass word upper", res, 24'hC00100);
    check("bypass rate", 24'(k), 24'h000003);
    $display("test bypass done");
  endtask
  task automatic t_fir();
    src.wr(REG_FINE, 16'h0000);
    src.wr(REG_COEF, 16'h0000);
    src.wr(REG_COEF, 16'h0004);
    src.wr(REG_CTRL, 16'h0000);
    count_res(24, k);
    check("fir growth upper", res, 24'hFFC001);
    ubs = 1'b0;
    lo_n = 1'b1;
    count_res(8, k);
    check("fir low float", oe, 24'hFF0000);
    lo_n = 1'b0;
    check("fir fraction upper", res, 24'h00C001);
    check("fir rate", 24'(k), 24'h000002);
    $display("test fir done");
  endtask
  task automatic t_fifo();
    src.wr(REG_CTRL, 16'h0801);
    // let fir work still in flight finish before the stall
    count_res(8, k);
    @(negedge fclk);
    src.f_run = 1'b0;
    repeat (12) @(negedge sclk);
    src.s_run = 1'b0;
    src.f_run = 1'b1;
    count_res(14, k);
    // the staging word ahead of the fifo holds one more
    check("fifo drain", 24'(k), 24'(FIFO_D + 1));
    src.s_run = 1'b1;
    $display("test fifo done");
  endtask
  task automatic t_ratio();
    src.wr(REG_CRATIO, 16'h0003);
    count_res(16, k);
    count_res(48, k);
    check("coarse ratio", 24'(k), 24'h000003);
    $display("test ratio done");
  endtask
  initial begin
    rst_n = 1'b0;
    ubs = 1'b1;
    lo_n = 1'b0;
    hi_n = 1'b0;
    do_reset();
    t_quiet();
    t_bypass();
    t_fir();
    t_fifo();
    t_ratio();
    do_reset();
    t_quiet();
    end_of_test();
  end
  initial begin
    #100us;
    failures++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end
endmodule

/* sim/tsdf_source.sv */
module tsdf_source import tsdf_pkg::*; (
  input wire logic i_core_clk,
  output logic o_sample_clock,
  output logic o_filter_clock,
  output logic [SMP_W-1:0] o_sample,
  output logic [PAR_W-1:0] o_par,
  output logic [1:0] o_sel,
  output logic o_cs_n,
  output logic o_wr_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic s_run = 1'b1;
  logic f_run = 1'b1;
  int ph = 0;
  initial begin
    o_sample_clock = 1'b0;
    o_filter_clock = 1'b0;
    o_sample = 16'hC001;
    o_par = 16'hA5A5;
    o_sel = 2'h0;
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
  end
  // one phase count feeds both clocks, sample clock is filter clock over four
  always @(posedge i_core_clk) begin
    ph <= #1 (ph == 39) ? 0 : ph + 1;
    o_filter_clock <= #1 f_run && (ph % 10 < 5);
    o_sample_clock <= #1 s_run && (ph < 20);
    if (ph == 20)
      o_sample <= #1 16'hC001;
  end
  task automatic wr(input logic [1:0] sel, input logic [PAR_W-1:0] d);
    @(posedge i_core_clk) #1;
    o_cs_n = 1'b0;
    o_wr_n = 1'b0;
    o_sel = sel;
    o_par = d;
    repeat (4) @(posedge i_core_clk);
    #1 o_wr_n = 1'b1;
    repeat (4) @(posedge i_core_clk);
    #1 o_cs_n = 1'b1;
    // released bus shows junk, not the last value
    o_sel = ~sel;
    o_par = ~d;
    repeat (4) @(posedge i_core_clk);
    #1;
  endtask
endmodule

/* sim/tsdf_top_properties.sv */
module tsdf_top_properties import tsdf_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_filter_clock,
  input wire logic i_chip_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_low_word_output_enable_n,
  input wire logic i_high_byte_output_enable_n,
  input wire logic [RES_W-1:0] o_result_bus,
  input wire logic [RES_W-1:0] o_result_bus_oe,
  input wire logic o_result_valid
);
  typedef struct packed {
    logic [7:0] fcnt;
    logic fprev;
    logic wrote;
    logic seen;
  } tsdf_chk_t;
  tsdf_chk_t st_r;
  tsdf_chk_t st_nxt;
  // cycles since the filter pin rose, saturating so long stops stay quiet
  always_comb begin
    st_nxt = st_r;
    st_nxt.fprev = i_filter_clock;
    if (i_filter_clock && !st_r.fprev)
      st_nxt.fcnt = 8'h00;
    else if (st_r.fcnt != 8'hFF)
      st_nxt.fcnt = st_r.fcnt + 8'h01;
    if (!i_chip_select_n && !i_write_strobe_n)
      st_nxt.wrote = 1'b1;
    if (o_result_valid)
      st_nxt.seen = 1'b1;
  end
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      st_r <= '{fcnt: 8'hFF, default: '0};
    else
      st_r <= st_nxt;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  a_lo_word_float: assert property (i_low_word_output_enable_n [*8] |-> o_result_bus_oe[15:0] == 16'h0000)
    else $error("low word driven while disabled");
  a_lo_word_drive: assert property (!i_low_word_output_enable_n [*8] |-> o_result_bus_oe[15:0] == 16'hFFFF)
    else $error("low word not driven while enabled");
  a_hi_byte_float: assert property (i_high_byte_output_enable_n [*8] |-> o_result_bus_oe[23:16] == 8'h00)
    else $error("high byte driven while disabled");
  a_hi_byte_drive: assert property (!i_high_byte_output_enable_n [*8] |-> o_result_bus_oe[23:16] == 8'hFF)
    else $error("high byte not driven while enabled");
  a_valid_on_fclk: assert property ($changed(o_result_valid) |-> st_r.fcnt >= 8'h01 && st_r.fcnt <= 8'h08)
    else $error("valid moved away from a filter clock rise");
  a_valid_full_span: assert property ($rose(o_result_valid) |-> o_result_valid [*6])
    else $error("valid shorter than a filter period");
  a_quiet_after_reset: assert property (!st_r.wrote |-> !o_result_valid)
    else $error("result before any configuration");
  a_word_clear_reset: assert property (!st_r.seen && !o_result_valid |-> o_result_bus == 24'h000000)
    else $error("result word not clear after reset");
  c_result: cover property ($rose(o_result_valid));
  c_neg_upper: cover property (o_result_valid && o_result_bus[23:16] == 8'hFF);
  c_lo_float: cover property (i_low_word_output_enable_n && o_result_valid);
endmodule
bind tsdf_top tsdf_top_properties chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_filter_clock(i_filter_clock), .i_chip_select_n(i_chip_select_n), .i_write_strobe_n(i_write_strobe_n),
  .i_low_word_output_enable_n(i_low_word_output_enable_n),
  .i_high_byte_output_enable_n(i_high_byte_output_enable_n), .o_result_bus(o_result_bus),
  .o_result_bus_oe(o_result_bus_oe), .o_result_valid(o_result_valid));
